// ### acs_defs.svh
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
// channel count and word layout
`define ACS_CHANNELS      48
`define ACS_RESULT_BITS   12
`define ACS_WORD_BITS     16
// timing in nanoseconds, clock period 10 ns
`define ACS_CLK_PERIOD_NS 10
`define ACS_SETTLE_NS     13600
`define ACS_CONVERT_NS    25000
// settling is a least time: round up
`define ACS_SETTLE_CYC    ((`ACS_SETTLE_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
// conversion time for the approximation pacing, per bit
`define ACS_BIT_CYC       ((`ACS_CONVERT_NS / `ACS_CLK_PERIOD_NS) / `ACS_RESULT_BITS)
`endif

// ### acs_pkg.sv
`include "acs_defs.svh"
package acs_pkg;
  typedef enum logic [2:0] {
    ACS_IDLE   = 3'b000,
    ACS_SETTLE = 3'b001,
    ACS_CONV   = 3'b010,
    ACS_SHIFT  = 3'b011
  } acs_state_t;
endpackage

// ### acs_sar.sv
`timescale 1ns/1ps
`include "acs_defs.svh"
// ==========================================
// successive approximation register
module acs_sar
  import acs_pkg::*;
#(
  parameter int BITS    = `ACS_RESULT_BITS,
  parameter int BIT_CYC = `ACS_BIT_CYC
) (
  input  wire logic            clock,
  input  wire logic            rstn,
  input  wire logic            start,
  input  wire logic            comp_high,
  output logic [BITS-1:0]      dac_code,
  output logic [BITS-1:0]      result,
  output logic                 done
);
  typedef struct packed {
    logic [BITS-1:0] trial;
    logic [BITS-1:0] mask;
    logic [15:0]     pace;
    logic            busy;
    logic [BITS-1:0] res;
    logic            done;
  } acs_sar_st_t;

  acs_sar_st_t s;
  acs_sar_st_t next_s;

  // keep the trial bit only when the input is above the trial level
  function automatic logic [BITS-1:0] decide(
    input logic [BITS-1:0] trial,
    input logic [BITS-1:0] mask,
    input logic            above
  );
    return above ? trial : (trial & ~mask);
  endfunction

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (start && !s.busy) begin
      next_s.busy  = 1'b1;
      next_s.mask  = {1'b1, {(BITS-1){1'b0}}};
      next_s.trial = {1'b1, {(BITS-1){1'b0}}};
      next_s.pace  = 16'h0000;
    end else if (s.busy) begin
      if (s.pace == 16'(BIT_CYC - 1)) begin
        next_s.pace = 16'h0000;
        next_s.trial = decide(s.trial, s.mask, comp_high);
        if (s.mask[0]) begin
          next_s.busy = 1'b0;
          next_s.res  = decide(s.trial, s.mask, comp_high);
          next_s.done = 1'b1;
        end else begin
          next_s.mask  = s.mask >> 1;
          next_s.trial = decide(s.trial, s.mask, comp_high) | (s.mask >> 1);
        end
      end else begin
        next_s.pace = s.pace + 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dac_code = s.trial;
  assign result   = s.res;
  assign done     = s.done;
endmodule

// ### acs_seq.sv
`timescale 1ns/1ps
// What this block does
// - route 48 channels into one converter
// - close switch at an even slot start when idle
// - wait 13.6 us settling before convert
// - 12-bit successive approximation in 25 us
// - whole conversion fits one slot
// - shift result out in low 12 bits
`include "acs_defs.svh"
module acs_seq
  import acs_pkg::*;
#(
  parameter int CHANNELS   = `ACS_CHANNELS,
  parameter int SETTLE_CYC = `ACS_SETTLE_CYC,
  parameter int BIT_CYC    = `ACS_BIT_CYC
) (
  input  wire logic                    clock,
  input  wire logic                    rstn,
  input  wire logic                    slot_start,
  input  wire logic                    slot_even,
  input  wire logic                    comp_high_pin,
  output logic [5:0]                   mux_select,
  output logic                         mux_close,
  output logic                         convert_cmd,
  output logic [`ACS_RESULT_BITS-1:0]  dac_code,
  output logic                         serial_data,
  output logic                         serial_shift,
  output logic                         serial_load,
  output logic                         slot_overrun
);
  // =============================
  // word layout
  localparam int RES_BITS  = `ACS_RESULT_BITS;
  localparam int WORD_BITS = `ACS_WORD_BITS;
  localparam int PAD_BITS  = WORD_BITS - RES_BITS;

  // =============================
  // state
  typedef struct packed {
    acs_state_t                 state;
    logic [5:0]                 chan;
    logic                       close;
    logic [15:0]                count;
    logic                       conv;
    logic [`ACS_WORD_BITS-1:0]  word;
    logic [4:0]                 bits_left;
    logic                       sdata;
    logic                       sshift;
    logic                       sload;
    logic                       overrun;
    logic [1:0]                 comp_sync;
    logic [`ACS_RESULT_BITS-1:0] dac;
  } acs_seq_st_t;

  acs_seq_st_t s;
  acs_seq_st_t next_s;
  logic [`ACS_RESULT_BITS-1:0] sar_result;
  logic [`ACS_RESULT_BITS-1:0] sar_code;
  logic                        sar_done;

  // =============================
  // helpers
  // an even slot start is the only request taken
  function automatic logic even_start(
    input logic start,
    input logic even
  );
    return start && even;
  endfunction

  // switch and converter are tied up from closure to result
  function automatic logic converting(
    input acs_state_t st
  );
    return (st == ACS_SETTLE) || (st == ACS_CONV);
  endfunction

  // a slot boundary inside a conversion, or an even slot refused while busy
  function automatic logic slot_clash(
    input logic       start,
    input logic       even,
    input acs_state_t st
  );
    return (start && converting(st)) || (even_start(start, even) && (st != ACS_IDLE));
  endfunction

  function automatic logic settled(
    input logic [15:0] count
  );
    return count == 16'(SETTLE_CYC - 1);
  endfunction

  function automatic logic [5:0] next_channel(
    input logic [5:0] chan
  );
    return (chan == 6'(CHANNELS - 1)) ? 6'h00 : chan + 6'h01;
  endfunction

  // result in the low bits, zero padding above
  function automatic logic [WORD_BITS-1:0] pack_word(
    input logic [RES_BITS-1:0] result
  );
    return {{PAD_BITS{1'b0}}, result};
  endfunction

  function automatic logic word_sent(
    input logic [4:0] left
  );
    return left == 5'h00;
  endfunction

  function automatic logic [WORD_BITS-1:0] shift_step(
    input logic [WORD_BITS-1:0] word
  );
    return {word[WORD_BITS-2:0], 1'b0};
  endfunction

  // pin sample moves one stage per clock
  function automatic logic [1:0] sync_step(
    input logic [1:0] sync,
    input logic       pin
  );
    return {sync[0], pin};
  endfunction

  // =============================
  // converter
  acs_sar #(
    .BITS    (`ACS_RESULT_BITS),
    .BIT_CYC (BIT_CYC)
  ) u_sar (
    .clock     (clock),
    .rstn      (rstn),
    .start     (s.conv),
    .comp_high (s.comp_sync[1]),
    .dac_code  (sar_code),
    .result    (sar_result),
    .done      (sar_done)
  );

  // =============================
  // sequencing
  always_comb begin
    next_s = s;
    next_s.comp_sync = sync_step(s.comp_sync, comp_high_pin);
    next_s.conv      = 1'b0;
    next_s.sshift    = 1'b0;
    next_s.sload     = 1'b0;
    next_s.dac       = sar_code;
    // slot clashes stay flagged until reset
    if (slot_clash(slot_start, slot_even, s.state)) begin
      next_s.overrun = 1'b1;
    end
    unique case (s.state)
      ACS_IDLE: begin
        if (even_start(slot_start, slot_even)) begin
          next_s.close = 1'b1;
          next_s.count = 16'h0000;
          next_s.state = ACS_SETTLE;
        end
      end

      ACS_SETTLE: begin
        if (settled(s.count)) begin
          next_s.conv  = 1'b1;
          next_s.state = ACS_CONV;
        end else begin
          next_s.count = s.count + 16'h0001;
        end
      end

      ACS_CONV: begin
        // the switch stays closed until the result is in
        if (sar_done) begin
          next_s.close     = 1'b0;
          next_s.word      = pack_word(sar_result);
          next_s.bits_left = 5'(WORD_BITS);
          next_s.state     = ACS_SHIFT;
        end
      end

      ACS_SHIFT: begin
        if (word_sent(s.bits_left)) begin
          next_s.sload = 1'b1;
          next_s.chan  = next_channel(s.chan);
          next_s.state = ACS_IDLE;
        end else begin
          // msb first so the result lands in the low bits
          next_s.sdata     = s.word[WORD_BITS-1];
          next_s.sshift    = 1'b1;
          next_s.word      = shift_step(s.word);
          next_s.bits_left = s.bits_left - 5'h01;
        end
      end

      default: begin
        next_s.close = 1'b0;
        next_s.state = ACS_IDLE;
      end
    endcase
  end

  // =============================
  // registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // =============================
  // outputs
  assign mux_select   = s.chan;
  assign mux_close    = s.close;
  assign convert_cmd  = s.conv;
  assign dac_code     = s.dac;
  assign serial_data  = s.sdata;
  assign serial_shift = s.sshift;
  assign serial_load  = s.sload;
  assign slot_overrun = s.overrun;
endmodule

// ### acs_sva.sv
`timescale 1ns/1ps
// ==========
// port checks
module acs_sva #(parameter int SETTLE_CYC = 4) (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       slot_start,
  input wire logic       slot_even,
  input wire logic [5:0] mux_select,
  input wire logic       mux_close,
  input wire logic       convert_cmd,
  input wire logic       serial_data,
  input wire logic       serial_shift,
  input wire logic       serial_load
);
  logic [4:0] bits;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn) bits <= 5'h00;
    else if (serial_load) bits <= 5'h00;
    else if (serial_shift) bits <= bits + 5'h01;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_sel; mux_select < 6'h30; endproperty
  a_sel: assert property (p_sel) else $error("bad channel");
  property p_close; $rose(mux_close) |-> $past(slot_start && slot_even); endproperty
  a_close: assert property (p_close) else $error("bad close");
  property p_settle; $rose(mux_close) |-> ##SETTLE_CYC convert_cmd; endproperty
  a_settle: assert property (p_settle) else $error("late convert");
  property p_early; convert_cmd |-> $past(mux_close, SETTLE_CYC); endproperty
  a_early: assert property (p_early) else $error("early convert");
  property p_conv; convert_cmd |-> ##[40:90] $fell(mux_close); endproperty
  a_conv: assert property (p_conv) else $error("slow convert");
  property p_zero; serial_shift && bits < 5'h04 |-> !serial_data; endproperty
  a_zero: assert property (p_zero) else $error("upper bit set");
  property p_load; serial_load |-> bits == 5'h10; endproperty
  a_load: assert property (p_load) else $error("bad bit count");
endmodule

// ### acs_analog_model.sv
`timescale 1ns/1ps
// ==========
// sensor levels through the switch
module acs_analog_model (
  input  wire logic              clock,
  input  wire logic [47:0][11:0] level,
  input  wire logic [5:0]        mux_select,
  input  wire logic              mux_close,
  input  wire logic [11:0]       dac_code,
  output logic                   comp_high
);
  logic toggle = 1'b0;
  always @(posedge clock) toggle <= !toggle;
  // level sits half a step above its code; open switch gives no steady level
  assign comp_high = mux_close ? level[mux_select] >= dac_code : toggle;
endmodule

// ### acs_seq_tb_top.sv
`timescale 1ns/1ps
module acs_seq_tb_top;
  logic              clock = 1'b0, rstn = 1'b0, slot_start = 1'b0, slot_even = 1'b0;
  logic              comp_high_pin, mux_close, convert_cmd, serial_data, serial_shift, serial_load, slot_overrun;
  logic [5:0]        mux_select;
  logic [11:0]       dac_code;
  logic [47:0][11:0] level = '0;
  int                failures = 0, compares = 0;
  always #5 clock = !clock;
  acs_seq #(
    .SETTLE_CYC (4),
    .BIT_CYC    (4)
  ) acs_seq_inst (
    .clock         (clock),
    .rstn          (rstn),
    .slot_start    (slot_start),
    .slot_even     (slot_even),
    .comp_high_pin (comp_high_pin),
    .mux_select    (mux_select),
    .mux_close     (mux_close),
    .convert_cmd   (convert_cmd),
    .dac_code      (dac_code),
    .serial_data   (serial_data),
    .serial_shift  (serial_shift),
    .serial_load   (serial_load),
    .slot_overrun  (slot_overrun)
  );
  acs_analog_model acs_analog_model_inst (
    .clock      (clock),
    .level      (level),
    .mux_select (mux_select),
    .mux_close  (mux_close),
    .dac_code   (dac_code),
    .comp_high  (comp_high_pin)
  );
  task check(input logic ok, input string msg);
    compares++;
    if (!ok) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task slot(input logic even);
    @(posedge clock);
    #1 slot_start = 1'b1;
    slot_even = even;
    @(posedge clock);
    #1 slot_start = 1'b0;
  endtask
  function automatic logic [15:0] word_of(input logic [11:0] v);
    return {4'h0, v};
  endfunction
  // ==========
  // tests
  initial begin
    logic [15:0] w;
    int          ch, i, base;
    void'($urandom(32'h5A14));
    base = 0;
    repeat (2) @(posedge clock);
    #1 rstn = 1'b1;
    for (int n = 0; n < 75; n++) begin
      if (n == 50) begin
        @(posedge clock);
        #1 rstn = 1'b0;
        @(negedge clock);
        check(slot_overrun === 1'b0 && mux_close === 1'b0 && serial_shift === 1'b0, "reset");
        @(posedge clock);
        #1 rstn = 1'b1;
        base = 50;
      end
      ch = (n - base) % 48;
      level[ch] = n == 0 ? 12'h000 : n == 1 ? 12'hFFF : 12'($urandom);
      if ($urandom % 2) begin
        slot(1'b0);
        repeat (3) @(negedge clock);
        check(mux_close === 1'b0, "odd slot");
      end
      slot(1'b1);
      repeat (2) @(negedge clock);
      check(mux_close === 1'b1 && mux_select === 6'(ch), "switch");
      w = '0;
      i = 0;
      while (serial_load !== 1'b1 && i < 400) begin
        @(negedge clock);
        if (serial_shift === 1'b1) w = {w[14:0], serial_data};
        if (n == 7 && i == 9) slot(1'b0);
        if (n == 57 && i == 9) slot(1'b1);
        i++;
      end
      check(w === word_of(level[ch]), "word");
      check(slot_overrun === ((n >= 7 && n < 50) || n >= 57), "overrun");
    end
    end_of_test;
  end
  initial begin
    #200000;
    failures++;
    end_of_test;
  end
endmodule
bind acs_seq acs_sva #(
  .SETTLE_CYC (SETTLE_CYC)
) acs_sva_inst (
  .clock        (clock),
  .rstn         (rstn),
  .slot_start   (slot_start),
  .slot_even    (slot_even),
  .mux_select   (mux_select),
  .mux_close    (mux_close),
  .convert_cmd  (convert_cmd),
  .serial_data  (serial_data),
  .serial_shift (serial_shift),
  .serial_load  (serial_load)
);
